// ---- rtl/bfp_fft_pkg.sv ----
// shared types and constants for the block-floating-point transform engine
package bfp_fft_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_POINTS  = 8;
  localparam int DATA_W    = 16;
  localparam int EXP_W     = 5;
  localparam int ROUND_POS = 15;

  // ----------------------------------------------------------------
  // headroom masks: bits that must be clear before a pass
  // ----------------------------------------------------------------
  localparam logic [15:0] R4_GUARD_MASK = 16'h7000;
  localparam logic [15:0] R2_GUARD_MASK = 16'h4000;

  // ----------------------------------------------------------------
  // twiddle table, q15, index = (butterfly * leg) of the radix-4 pass
  // ----------------------------------------------------------------
  localparam logic signed [15:0] TW_RE_1 = 16'sh5A82;
  localparam logic signed [15:0] TW_IM_1 = 16'shA57E;
  localparam logic signed [15:0] TW_RE_2 = 16'sh0000;
  localparam logic signed [15:0] TW_IM_2 = 16'sh8000;
  localparam logic signed [15:0] TW_RE_3 = 16'shA57E;
  localparam logic signed [15:0] TW_IM_3 = 16'shA57E;

  // ----------------------------------------------------------------
  // reset values and last index of each count
  // ----------------------------------------------------------------
  localparam logic [2:0]       IDX_RST   = 3'h0;
  localparam logic [1:0]       SHIFT_RST = 2'h0;
  localparam logic [EXP_W-1:0] EXP_RST   = 5'h00;
  localparam logic [15:0]      MAG_RST   = 16'h0000;
  localparam logic [2:0]       IDX_LAST  = 3'h7;
  localparam logic [2:0]       R4_LAST   = 3'h1;
  localparam logic [2:0]       R2_LAST   = 3'h3;

  typedef struct packed {
    logic signed [DATA_W-1:0] re;
    logic signed [DATA_W-1:0] im;
  } cplx_type;

  typedef enum logic [1:0] {
    PH_LOAD   = 2'h0,
    PH_R4     = 2'h1,
    PH_R2     = 2'h3,
    PH_UNLOAD = 2'h2
  } phase_type;

endpackage : bfp_fft_pkg

// ---- rtl/bfp_fft_engine.sv ----
// block-floating-point radix-4/2 transform engine, 8 points, forward or inverse
//
// Contract
// (RL1) Compute the length-N DFT, forward or inverse, at N unit-circle points.
// (RL2) Inverse results are not divided by N; caller normalises.
// (RL3) Radix-4 butterflies over four-point groups, only trivial multiplies inside.
// (RL4) Full complex multiplies only in twiddle rotation after each butterfly.
// (RL5) Every pass reuses one butterfly: read memory, compute, write back.
// (RL6) Odd power of two length ends with a radix-2 pass.
// (RL7) Values keep own mantissa; whole block shares one exponent.
// (RL8) Upstream supplies fixed-point complex samples with no exponent.
// (RL9) Each radix-4 pass may grow words 2.5 bits without overflow.
// (RL10) Before each pass shift block by range measured on previous output.
// (RL11) Sum of all pass shifts is output as the block exponent.
// (RL12) Shift discards as few low bits as possible before rounding.
// (RL13) Downstream rescales each block by its own final exponent.
// (RL14) Full-precision comparison multiplies output by two to minus exponent; the bench multiplies by two to the exponent.
// (RL15) Both data interfaces honour backpressure from the receiving side.
// (RL16) Exponent is presented alongside the samples of its own block.
`timescale 1ns/10ps
module bfp_fft_engine
  import bfp_fft_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire cplx_type   in_data,
  input  wire logic       in_inverse,
  output logic            out_valid,
  input  wire logic       out_ready,
  output cplx_type        out_data,
  output logic [EXP_W-1:0] out_exp
);

  typedef struct packed {
    phase_type              phase;
    logic [2:0]             idx;
    logic                   inverse;
    logic [1:0]             shift;
    logic [EXP_W-1:0]       exp;
    logic [15:0]            mag;
    logic [15:0]            pmag;
    cplx_type [N_POINTS-1:0] mem;
    logic                   in_ready;
    logic                   out_valid;
    cplx_type               out_data;
    logic [EXP_W-1:0]       out_exp;
  } engine_type;

  engine_type st;
  engine_type next_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one's-complement magnitude, or-ed over both parts: cheap and conservative
  function automatic logic [15:0] mag_of(input cplx_type v);
    mag_of = (v.re ^ {16{v.re[15]}}) | (v.im ^ {16{v.im[15]}});
  endfunction : mag_of

  function automatic logic [1:0] r4_shift(input logic [15:0] m);
    if (m[14])      r4_shift = 2'h3; // RL9
    else if (m[13]) r4_shift = 2'h2; // RL12
    else if (m[12]) r4_shift = 2'h1;
    else            r4_shift = 2'h0;
  endfunction : r4_shift

  function automatic logic [1:0] r2_shift(input logic [15:0] m);
    r2_shift = m[14] ? 2'h1 : 2'h0; // RL6 RL12
  endfunction : r2_shift

  function automatic cplx_type scaled(input cplx_type v, input logic [1:0] s);
    scaled.re = v.re >>> s; // RL10
    scaled.im = v.im >>> s;
  endfunction : scaled

  // twiddle rotation; inverse uses the conjugate factor, never a 1/N scale
  function automatic cplx_type rotate(input logic signed [17:0] re, input logic signed [17:0] im,
                                      input logic [1:0] t, input logic inv);
    logic signed [15:0] wr;
    logic signed [15:0] wi;
    logic signed [34:0] pr;
    logic signed [34:0] pi;
    wr = TW_RE_1;
    wi = TW_IM_1;
    unique case (t)
      2'h0: begin wr = TW_RE_1; wi = TW_IM_1; end
      2'h1: begin wr = TW_RE_1; wi = TW_IM_1; end
      2'h2: begin wr = TW_RE_2; wi = TW_IM_2; end
      2'h3: begin wr = TW_RE_3; wi = TW_IM_3; end
    endcase
    if (inv) begin // RL1 RL2
      pr = 35'(re * wr) + 35'(im * wi);
      pi = 35'(im * wr) - 35'(re * wi);
    end else begin
      pr = 35'(re * wr) - 35'(im * wi); // RL4
      pi = 35'(im * wr) + 35'(re * wi);
    end
    // round once, right after the product, keeping every bit up to here
    pr = (pr + (35'sd1 <<< (ROUND_POS - 1))) >>> ROUND_POS; // RL12
    pi = (pi + (35'sd1 <<< (ROUND_POS - 1))) >>> ROUND_POS;
    if (t == 2'h0) begin
      rotate.re = re[15:0];
      rotate.im = im[15:0];
    end else begin
      rotate.re = pr[15:0];
      rotate.im = pi[15:0];
    end
  endfunction : rotate

  // natural-order output: bin k sits at position {k mod 4, k div 4}
  function automatic logic [2:0] out_pos(input logic [2:0] k);
    out_pos = {k[1:0], k[2]};
  endfunction : out_pos

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    cplx_type a;
    cplx_type b;
    cplx_type c;
    cplx_type d;
    logic signed [17:0] s0r, s0i, s1r, s1i, t0r, t0i, t1r, t1i, jr, ji;
    logic [1:0] bi;
    logic [15:0] new_mag;
    next_st = st;
    a = '0;
    b = '0;
    c = '0;
    d = '0;
    s0r = '0; s0i = '0; s1r = '0; s1i = '0;
    t0r = '0; t0i = '0; t1r = '0; t1i = '0;
    jr = '0; ji = '0;
    bi = {1'b0, st.idx[0]};
    new_mag = st.mag;
    unique case (st.phase)
      PH_LOAD: begin
        if (in_valid && st.in_ready) begin // RL15
          next_st.mem[st.idx] = in_data; // RL8
          new_mag = st.mag | mag_of(in_data);
          if (st.idx == IDX_RST) next_st.inverse = in_inverse;
          next_st.idx = st.idx + 3'h1;
          next_st.mag = new_mag;
          if (st.idx == IDX_LAST) begin
            next_st.phase = PH_R4;
            next_st.idx   = IDX_RST;
            next_st.shift = r4_shift(new_mag); // RL10
            next_st.exp   = EXP_W'(r4_shift(new_mag)); // RL11
            next_st.pmag  = new_mag;
            next_st.mag   = MAG_RST;
          end
        end
      end
      PH_R4: begin
        // one radix-4 butterfly per cycle over stride-2 legs
        a = scaled(st.mem[st.idx], st.shift); // RL5
        b = scaled(st.mem[st.idx + 3'h2], st.shift);
        c = scaled(st.mem[st.idx + 3'h4], st.shift);
        d = scaled(st.mem[st.idx + 3'h6], st.shift);
        s0r = 18'(a.re) + 18'(c.re); s0i = 18'(a.im) + 18'(c.im); // RL3
        s1r = 18'(a.re) - 18'(c.re); s1i = 18'(a.im) - 18'(c.im);
        t0r = 18'(b.re) + 18'(d.re); t0i = 18'(b.im) + 18'(d.im);
        t1r = 18'(b.re) - 18'(d.re); t1i = 18'(b.im) - 18'(d.im);
        // multiply by -j forward or +j inverse is only a swap and negate
        jr = st.inverse ? -t1i : t1i; // RL3
        ji = st.inverse ? t1r : -t1r;
        next_st.mem[st.idx]        = rotate(s0r + t0r, s0i + t0i, 2'h0, st.inverse);
        next_st.mem[st.idx + 3'h2] = rotate(s1r + jr, s1i + ji, bi, st.inverse); // RL4
        next_st.mem[st.idx + 3'h4] = rotate(s0r - t0r, s0i - t0i, 2'(bi * 2'h2), st.inverse);
        next_st.mem[st.idx + 3'h6] = rotate(s1r - jr, s1i - ji, 2'(bi * 2'h3), st.inverse);
        new_mag = st.mag | mag_of(next_st.mem[st.idx]) | mag_of(next_st.mem[st.idx + 3'h2])
                | mag_of(next_st.mem[st.idx + 3'h4]) | mag_of(next_st.mem[st.idx + 3'h6]);
        next_st.mag = new_mag;
        next_st.idx = st.idx + 3'h1;
        if (st.idx == R4_LAST) begin
          next_st.phase = PH_R2; // RL6
          next_st.idx   = IDX_RST;
          next_st.shift = r2_shift(new_mag); // RL10
          next_st.exp   = st.exp + EXP_W'(r2_shift(new_mag)); // RL11
          next_st.pmag  = new_mag;
          next_st.mag   = MAG_RST;
        end
      end
      PH_R2: begin
        a = scaled(st.mem[{st.idx[1:0], 1'b0}], st.shift); // RL5
        b = scaled(st.mem[{st.idx[1:0], 1'b1}], st.shift);
        next_st.mem[{st.idx[1:0], 1'b0}] = '{re: 16'(a.re + b.re), im: 16'(a.im + b.im)}; // RL6
        next_st.mem[{st.idx[1:0], 1'b1}] = '{re: 16'(a.re - b.re), im: 16'(a.im - b.im)};
        next_st.idx = st.idx + 3'h1;
        if (st.idx == R2_LAST) begin
          next_st.phase     = PH_UNLOAD;
          next_st.idx       = IDX_RST;
          next_st.out_valid = 1'b1;
          next_st.out_data  = next_st.mem[out_pos(IDX_RST)];
          next_st.out_exp   = st.exp; // RL16
        end
      end
      PH_UNLOAD: begin
        if (out_ready) begin // RL15
          next_st.idx = st.idx + 3'h1;
          next_st.out_data = st.mem[out_pos(st.idx + 3'h1)]; // RL1
          if (st.idx == IDX_LAST) begin
            next_st.phase     = PH_LOAD;
            next_st.idx       = IDX_RST;
            next_st.out_valid = 1'b0;
            next_st.exp       = EXP_RST; // RL7
          end
        end
      end
    endcase
    next_st.in_ready = (next_st.phase == PH_LOAD);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.phase    <= PH_LOAD;
      st.in_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready  = st.in_ready;
  assign out_valid = st.out_valid;
  assign out_data  = st.out_data;
  assign out_exp   = st.out_exp;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence radix4_run;
    (st.phase == PH_R4)[*2];
  endsequence
  sequence radix2_run;
    (st.phase == PH_R2)[*4];
  endsequence

  a_pass_order: assert property ($rose(st.phase == PH_R4) |-> radix4_run ##1 radix2_run // RL5
                                 ##1 (st.phase == PH_UNLOAD && out_valid))
    else $error("pass order broken");
  a_r4_headroom: assert property (st.phase == PH_R4 |-> ((st.pmag >> st.shift) & R4_GUARD_MASK) == 0) // RL9
    else $error("radix-4 pass without headroom");
  a_r4_min_shift: assert property (st.phase == PH_R4 && st.shift != 0 // RL12
                                   |-> ((st.pmag >> (st.shift - 2'h1)) & R4_GUARD_MASK) != 0)
    else $error("radix-4 shift larger than needed");
  a_r2_headroom: assert property (st.phase == PH_R2 |-> ((st.pmag >> st.shift) & R2_GUARD_MASK) == 0) // RL10
    else $error("radix-2 pass without headroom");
  a_exp_total: assert property ($rose(out_valid) |-> out_exp == $past(st.exp) // RL11
                                && out_exp == EXP_W'($past(st.shift, 5)) + EXP_W'($past(st.shift)))
    else $error("exponent is not the sum of shifts");
  a_out_hold: assert property (out_valid && !out_ready |=> $stable(out_data) && $stable(out_exp)) // RL16
    else $error("output changed under backpressure");
  a_busy_refuse: assert property (st.phase != PH_LOAD |-> !in_ready && $stable(st.inverse)) // RL15
    else $error("input accepted while busy");
  a_block_end: assert property (out_valid && out_ready && st.idx == IDX_LAST // RL7
                                |=> !out_valid && in_ready && st.exp == EXP_RST)
    else $error("block did not close cleanly");

endmodule : bfp_fft_engine

// ---- testbench/bfp_stream_partner.sv ----
// upstream source and downstream sink models facing the transform engine
`timescale 1ns/10ps
module bfp_stream_partner
  import bfp_fft_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             in_ready,
  output logic                  in_valid,
  output cplx_type              in_data,
  output logic                  in_inverse,
  input  wire logic             out_valid,
  output logic                  out_ready,
  input  wire cplx_type         out_data,
  input  wire logic [EXP_W-1:0] out_exp,
  input  wire cplx_type         src [8],
  output cplx_type              dst [8],
  output logic [EXP_W-1:0]      dst_exp [8]
);
  initial begin
    in_valid   = 1'b0;
    in_data    = '0;
    in_inverse = 1'b0;
    out_ready  = 1'b0;
  end

  // ----------------------------------------------------------------
  // source: plain fixed-point samples, no exponent travels with them
  // ----------------------------------------------------------------
  task automatic send_block(input logic inv, input logic gap);
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk);
      in_valid   <= 1'b1;
      in_data    <= src[k];
      in_inverse <= (k == 0) ? inv : ~inv;
      do @(posedge mclk); while (!in_ready);
      if (gap) begin
        @(negedge mclk);
        in_valid <= 1'b0;
        in_data  <= ~src[k];
      end
    end
    // a stale word stays offered while the engine computes; it must not land
    @(negedge mclk);
    in_valid <= 1'b1;
    in_data  <= ~src[7];
    repeat (4) @(negedge mclk);
    in_valid <= 1'b0;
  endtask : send_block

  // ----------------------------------------------------------------
  // sink: optional stall on every other cycle
  // ----------------------------------------------------------------
  task automatic take_block(input logic stall);
    int k;
    k = 0;
    while (k < 8) begin
      @(negedge mclk);
      out_ready <= stall ? ~out_ready : 1'b1;
      @(posedge mclk);
      if (out_valid && out_ready) begin
        dst[k]     = out_data;
        dst_exp[k] = out_exp;
        k++;
      end
    end
    @(negedge mclk);
    out_ready <= 1'b0;
  endtask : take_block
endmodule : bfp_stream_partner

// ---- testbench/block_float_fft_engine_tb_top.sv ----
// self-checking bench for the block-floating-point transform engine
`timescale 1ns/10ps
module block_float_fft_engine_tb_top;
  import bfp_fft_pkg::*;
  logic             mclk;
  logic             rst_n;
  logic             in_valid;
  logic             in_ready;
  cplx_type         in_data;
  logic             in_inverse;
  logic             out_valid;
  logic             out_ready;
  cplx_type         out_data;
  logic [EXP_W-1:0] out_exp;
  cplx_type         src [8];
  cplx_type         dst [8];
  logic [EXP_W-1:0] dst_exp [8];
  int               bad_count;
  int               cmp_count;
  int               cycles;

  bfp_fft_engine bfp_fft_engine_i (.mclk(mclk), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .in_inverse(in_inverse), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_exp(out_exp));
  bfp_stream_partner bfp_stream_partner_i (.mclk(mclk), .in_ready(in_ready),
    .in_valid(in_valid), .in_data(in_data), .in_inverse(in_inverse), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .out_exp(out_exp), .src(src), .dst(dst),
    .dst_exp(dst_exp));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // hang guard, well above five blocks of about 40 cycles each
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic check_exp(input string name, input logic [EXP_W-1:0] want,
                           input logic [EXP_W-1:0] got);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", name, want, got);
    end
  endtask : check_exp

  task automatic check_flag(input string name, input logic want, input logic got);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", name, want, got);
    end
  endtask : check_flag

  task automatic check_near(input string name, input real want, input real got,
                            input real tol);
    cmp_count++;
    if (got - want > tol || want - got > tol) begin
      bad_count++;
      $display("wrong value %s expected %f seen %f", name, want, got);
    end
  endtask : check_near

  task automatic run_block(input logic inv, input logic gap, input logic stall);
    fork
      bfp_stream_partner_i.send_block(inv, gap);
      bfp_stream_partner_i.take_block(stall);
    join
  endtask : run_block

  // output scaled by two to the exponent must match the unnormalised transform
  task automatic check_block(input logic inv);
    real er, ei, ang, sc;
    for (int k = 0; k < 8; k++) begin
      er = 0.0;
      ei = 0.0;
      for (int n = 0; n < 8; n++) begin
        ang = (inv ? 1.0 : -1.0) * 6.283185307179586 * n * k / 8.0;
        er += $signed(src[n].re) * $cos(ang) - $signed(src[n].im) * $sin(ang);
        ei += $signed(src[n].re) * $sin(ang) + $signed(src[n].im) * $cos(ang);
      end
      sc = 2.0 ** dst_exp[k];
      check_exp("block exponent", dst_exp[0], dst_exp[k]);
      check_near("real part", er, $signed(dst[k].re) * sc, 8.0 * sc + 8.0);
      check_near("imag part", ei, $signed(dst[k].im) * sc, 8.0 * sc + 8.0);
    end
  endtask : check_block

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic small_impulse();
    foreach (src[n]) src[n] = '0;
    src[0] = '{16'h0100, 16'h0000};
    run_block(1'b0, 1'b0, 1'b0);
    check_block(1'b0);
    check_exp("small block exponent", 5'h00, dst_exp[0]);
  endtask : small_impulse

  task automatic large_dc();
    foreach (src[n]) src[n] = '{16'h4000, 16'hC000};
    run_block(1'b0, 1'b1, 1'b1);
    check_block(1'b0);
    check_exp("dc block exponent", 5'h03, dst_exp[0]);
  endtask : large_dc

  // reset lands in the radix-2 pass; outputs must fall back to idle at once
  task automatic reset_mid_block();
    bfp_stream_partner_i.send_block(1'b0, 1'b0);
    rst_n = 1'b0;
    @(negedge mclk);
    check_flag("ready in reset", 1'b1, in_ready);
    check_flag("valid in reset", 1'b0, out_valid);
    check_exp("exponent in reset", 5'h00, out_exp);
    check_near("data in reset", 0.0, $signed(out_data.re), 0.0);
    rst_n = 1'b1;
  endtask : reset_mid_block

  task automatic inverse_tone();
    foreach (src[n]) src[n] = '0;
    src[1] = '{16'h2000, 16'h0000};
    run_block(1'b1, 1'b0, 1'b1);
    check_block(1'b1);
    check_exp("tone block exponent", 5'h02, dst_exp[0]);
  endtask : inverse_tone

  task automatic ramp_forward();
    foreach (src[n]) src[n] = '{16'(n * 16'h0900), 16'(16'h0400 - n * 16'h0180)};
    run_block(1'b0, 1'b1, 1'b0);
    check_block(1'b0);
    check_exp("ramp block exponent", 5'h02, dst_exp[0]);
  endtask : ramp_forward

  initial begin
    bad_count = 0;
    cmp_count = 0;
    cycles    = 0;
    rst_n     = 1'b0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    small_impulse();
    large_dc();
    reset_mid_block();
    inverse_tone();
    ramp_forward();
    wrap_up();
  end
endmodule : block_float_fft_engine_tb_top
